// [design/gpc_defines.svh]
// register map, field positions, reset values and counts for the gpio pin-change block
`ifndef GPC_DEFINES_SVH
`define GPC_DEFINES_SVH

`define GPC_ADDR_W 8
`define GPC_NPORT 4
`define GPC_NGROUP 4

// per-port register triplets: sample, direction, out data
`define GPC_PORT_BASE 8'h20
`define GPC_PORT_STRIDE 8'h03
`define GPC_PIN_OFS 8'h00
`define GPC_DIR_OFS 8'h01
`define GPC_OUT_OFS 8'h02

`define GPC_FLAGS_ADDR 8'h3b
`define GPC_CORE_CTRL_ADDR 8'h30
`define GPC_GROUP_EN_ADDR 8'h68
`define GPC_MASK0_ADDR 8'h6b
`define GPC_MASK1_ADDR 8'h6c
`define GPC_MASK2_ADDR 8'h6d
`define GPC_MASK3_ADDR 8'h73

`define GPC_PULLUP_OFF_BIT 0

`define GPC_RST_BYTE 8'h00
`define GPC_RST_GROUP 4'h0

`endif

// [design/gpc_pkg.sv]
// shared types for the gpio pin-change block
package gpc_pkg;

    // one register-port access, byte write or single-bit set/clear
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic bit_set;
        logic bit_clr;
        logic [2:0] bit_sel;
    } gpc_io_req_s;

    // per-pin alternate function override
    typedef struct packed {
        logic [31:0] en;
        logic [31:0] oe;
        logic [31:0] data;
    } gpc_alt_s;

endpackage

// [design/gpc_pin_sync.sv]
// pin input synchroniser: falling-edge catch, two rising stages, agreement filter
`timescale 1ns/1ps
module gpc_pin_sync import gpc_pkg::*; #(
    parameter int W = 32
) (
    // clock and control
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    // pins
    input wire logic [W-1:0] async_in,
    // results
    output logic [W-1:0] sample_out,
    output logic [W-1:0] change_out
);

    logic [W-1:0] catch_n;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] accepted;
    wire [W-1:0] agree;

    // stands in for the latch that is open while the clock is high
    always_ff @(negedge clk_in) begin
        if (srst_in) begin
            catch_n <= '0;
        end else if (ce_in) begin
            catch_n <= async_in; // [R19]
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            stage2 <= '0;
            stage3 <= '0;
        end else if (ce_in) begin
            stage2 <= catch_n; // [R19]
            stage3 <= stage2;
        end
    end

    genvar b;
    generate
        for (b = 0; b < W; b++) begin : g_bit
            assign agree[b] = (stage2[b] == stage3[b]);
            always_ff @(posedge clk_in) begin
                if (srst_in) begin
                    accepted[b] <= 1'b0;
                end else if (ce_in && agree[b]) begin
                    accepted[b] <= stage3[b];
                end
            end
            // a change is the settled sample differing from the one before it
            assign change_out[b] = ce_in && agree[b] && (stage3[b] != accepted[b]); // [R20]
        end
    endgenerate

    assign sample_out = stage2;

endmodule

// [design/gpc_gpio_port_pin_change.sv]
// gpio ports with pin-change interrupt detection, top level
//
// Operation
// [R01] change on enabled pin sets group flag
// [R02] request needs flag, global enable, group enable
// [R03] entering routine clears that group flag
// [R04] writing one clears flag, zero keeps
// [R05] detect needs mask bit and group enable
// [R06] masked pin never raises a flag
// [R07] per port: out data, direction, pin sample
// [R08] one written to sample toggles out data
// [R09] global pull-up off overrides all pull-ups
// [R10] direction one output, zero input
// [R11] input with out data one enables pull-up
// [R12] out data zero or output kills pull-up
// [R13] reset tri-states pins without clock
// [R14] output pin drives out data level
// [R15] single-bit ops touch only their bit
// [R16] alternate function leaves other pins alone
// [R17] group 3 covers pins 31 to 24
// [R18] any enabled change requests group interrupt
// [R19] pins caught low phase, sampled next rise
// [R20] change is sample differing from previous
`timescale 1ns/1ps
`include "gpc_defines.svh"
module gpc_gpio_port_pin_change import gpc_pkg::*; (
    // clock, reset, enable
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic CE_IN,
    // register port
    input wire gpc_io_req_s IO_REQ_IN,
    output logic [7:0] IO_RDATA_OUT,
    output logic IO_RVALID_OUT,
    // processor interface
    input wire logic GLOBAL_IRQ_EN_IN,
    input wire logic [3:0] IRQ_ACK_IN,
    output logic [3:0] IRQ_REQ_OUT,
    // alternate function overrides
    input wire gpc_alt_s ALT_IN,
    // pins
    input wire logic [31:0] PIN_IN,
    output logic [31:0] PIN_OUT,
    output logic [31:0] PIN_OE_OUT,
    output logic [31:0] PIN_PULLUP_OUT
);

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [7:0] direction_reg [`GPC_NPORT];
    logic [7:0] out_data_reg [`GPC_NPORT];
    logic [7:0] pin_change_mask [`GPC_NGROUP];
    logic [3:0] group_enable_control;
    logic [3:0] pin_change_flags;
    logic global_pullup_off;
    logic [7:0] rdata;
    logic rvalid;

    wire [31:0] pin_sample;
    wire [31:0] pin_change;

    gpc_pin_sync #(
        .W(32)
    ) u_sync (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .ce_in(CE_IN),
        .async_in(PIN_IN),
        .sample_out(pin_sample),
        .change_out(pin_change)
    );

    ////////////////////////////////////////////////////////////////////////
    // access decode

    wire any_write = IO_REQ_IN.wr || IO_REQ_IN.bit_set || IO_REQ_IN.bit_clr;
    wire bit_op = IO_REQ_IN.bit_set || IO_REQ_IN.bit_clr;
    wire [7:0] bit_onehot = 8'h01 << IO_REQ_IN.bit_sel;
    // single-bit ops become a masked write of one bit only
    wire [7:0] wr_mask = bit_op ? bit_onehot : 8'hff; // [R15]
    wire [7:0] wr_val = IO_REQ_IN.bit_set ? 8'hff : (IO_REQ_IN.bit_clr ? 8'h00 : IO_REQ_IN.wdata);
    wire [7:0] wr_ones = wr_val & wr_mask;

    wire hit_flags = any_write && (IO_REQ_IN.addr == `GPC_FLAGS_ADDR);
    wire hit_gen = any_write && (IO_REQ_IN.addr == `GPC_GROUP_EN_ADDR);
    wire hit_core = any_write && (IO_REQ_IN.addr == `GPC_CORE_CTRL_ADDR);
    wire [7:0] mask_addr [`GPC_NGROUP];
    assign mask_addr[0] = `GPC_MASK0_ADDR;
    assign mask_addr[1] = `GPC_MASK1_ADDR;
    assign mask_addr[2] = `GPC_MASK2_ADDR;
    assign mask_addr[3] = `GPC_MASK3_ADDR;

    wire [7:0] next_core = ({7'h00, global_pullup_off} & ~wr_mask) | wr_ones;
    wire [7:0] next_gen = ({4'h0, group_enable_control} & ~wr_mask) | wr_ones;

    ////////////////////////////////////////////////////////////////////////
    // ports: registers and pad control

    wire [31:0] dir_flat;
    wire [31:0] out_flat;
    wire [7:0] port_rd [`GPC_NPORT];
    wire [3:0] port_hit_rd;

    genvar p;
    generate
        for (p = 0; p < `GPC_NPORT; p++) begin : g_port
            wire [7:0] base = `GPC_PORT_BASE + 8'(p) * `GPC_PORT_STRIDE;
            wire hit_pin = any_write && (IO_REQ_IN.addr == base + `GPC_PIN_OFS);
            wire hit_dir = any_write && (IO_REQ_IN.addr == base + `GPC_DIR_OFS);
            wire hit_out = any_write && (IO_REQ_IN.addr == base + `GPC_OUT_OFS);
            wire [7:0] merged_dir = (direction_reg[p] & ~wr_mask) | wr_ones; // [R15]
            wire [7:0] merged_out = (out_data_reg[p] & ~wr_mask) | wr_ones; // [R15]
            // sample register holds no storage; a one written there flips out data
            wire [7:0] next_out = hit_out ? merged_out :
                (hit_pin ? (out_data_reg[p] ^ wr_ones) : out_data_reg[p]); // [R08]
            wire [7:0] next_dir = hit_dir ? merged_dir : direction_reg[p]; // [R07]

            always_ff @(posedge CLK_IN) begin
                if (SRST_IN) begin
                    direction_reg[p] <= `GPC_RST_BYTE;
                    out_data_reg[p] <= `GPC_RST_BYTE;
                end else if (CE_IN) begin
                    direction_reg[p] <= next_dir;
                    out_data_reg[p] <= next_out;
                end
            end

            assign dir_flat[8*p +: 8] = direction_reg[p];
            assign out_flat[8*p +: 8] = out_data_reg[p];
            assign port_rd[p] = (IO_REQ_IN.addr == base + `GPC_PIN_OFS) ? pin_sample[8*p +: 8] :
                (IO_REQ_IN.addr == base + `GPC_DIR_OFS) ? direction_reg[p] : out_data_reg[p];
            assign port_hit_rd[p] = (IO_REQ_IN.addr == base + `GPC_PIN_OFS) ||
                (IO_REQ_IN.addr == base + `GPC_DIR_OFS) || (IO_REQ_IN.addr == base + `GPC_OUT_OFS);
        end
    endgenerate

    // each pin has its own override select, so neighbours keep gpio use
    genvar n;
    generate
        for (n = 0; n < 32; n++) begin : g_pad
            wire eff_oe = ALT_IN.en[n] ? ALT_IN.oe[n] : dir_flat[n]; // [R16]
            wire eff_out = ALT_IN.en[n] ? ALT_IN.data[n] : out_flat[n]; // [R16]
            // reset gates the pad directly so it floats even with no clock
            assign PIN_OE_OUT[n] = eff_oe && !SRST_IN; // [R13] [R10]
            assign PIN_OUT[n] = eff_out; // [R14]
            assign PIN_PULLUP_OUT[n] = !SRST_IN && !ALT_IN.en[n] && !dir_flat[n] &&
                out_flat[n] && !global_pullup_off; // [R09] [R11] [R12]
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // pin-change detection

    wire [3:0] pc_event;
    wire [3:0] pc_flag_next;
    wire [3:0] flag_w1c = hit_flags ? wr_ones[3:0] : 4'h0;

    genvar g;
    generate
        for (g = 0; g < `GPC_NGROUP; g++) begin : g_group
            wire hit_mask = any_write && (IO_REQ_IN.addr == mask_addr[g]);
            wire [7:0] enabled = pin_change_mask[g] & {8{group_enable_control[g]}}; // [R05] [R06]
            // group 3 takes pins 31:24, groups 0..2 the lower bytes in order
            assign pc_event[g] = |(pin_change[8*g +: 8] & enabled); // [R01] [R17] [R18]
            // a change in the clearing cycle is kept: set beats clear
            assign pc_flag_next[g] = pc_event[g] ||
                (pin_change_flags[g] && !flag_w1c[g] && !IRQ_ACK_IN[g]); // [R01] [R03] [R04]

            always_ff @(posedge CLK_IN) begin
                if (SRST_IN) begin
                    pin_change_mask[g] <= `GPC_RST_BYTE;
                end else if (CE_IN && hit_mask) begin
                    pin_change_mask[g] <= (pin_change_mask[g] & ~wr_mask) | wr_ones;
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            pin_change_flags <= `GPC_RST_GROUP;
            group_enable_control <= `GPC_RST_GROUP;
            global_pullup_off <= 1'b0;
        end else if (CE_IN) begin
            pin_change_flags <= pc_flag_next;
            if (hit_gen) begin
                group_enable_control <= next_gen[3:0];
            end
            if (hit_core) begin
                global_pullup_off <= next_core[`GPC_PULLUP_OFF_BIT];
            end
        end
    end

    assign IRQ_REQ_OUT = pin_change_flags & group_enable_control & {4{GLOBAL_IRQ_EN_IN}}; // [R02]

    ////////////////////////////////////////////////////////////////////////
    // read path, answered one cycle after the read strobe

    wire [7:0] port_rdata = port_hit_rd[0] ? port_rd[0] :
        port_hit_rd[1] ? port_rd[1] : port_hit_rd[2] ? port_rd[2] : port_rd[3];
    wire [7:0] rd_mux =
        (|port_hit_rd) ? port_rdata :
        (IO_REQ_IN.addr == `GPC_FLAGS_ADDR) ? {4'h0, pin_change_flags} :
        (IO_REQ_IN.addr == `GPC_GROUP_EN_ADDR) ? {4'h0, group_enable_control} :
        (IO_REQ_IN.addr == `GPC_CORE_CTRL_ADDR) ? {7'h00, global_pullup_off} :
        (IO_REQ_IN.addr == `GPC_MASK0_ADDR) ? pin_change_mask[0] :
        (IO_REQ_IN.addr == `GPC_MASK1_ADDR) ? pin_change_mask[1] :
        (IO_REQ_IN.addr == `GPC_MASK2_ADDR) ? pin_change_mask[2] :
        (IO_REQ_IN.addr == `GPC_MASK3_ADDR) ? pin_change_mask[3] : 8'h00;

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else if (CE_IN) begin
            rvalid <= IO_REQ_IN.rd;
            if (IO_REQ_IN.rd) begin
                rdata <= rd_mux; // [R07]
            end
        end
    end

    assign IO_RDATA_OUT = rdata;
    assign IO_RVALID_OUT = rvalid;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (SRST_IN);

    wire plain_write = IO_REQ_IN.wr && !bit_op;
    wire port0_quiet = (ALT_IN.en[7:0] == 8'h00);

    sequence s_dir0_write;
        CE_IN && plain_write && (IO_REQ_IN.addr == `GPC_PORT_BASE + `GPC_DIR_OFS);
    endsequence

    sequence s_dir0_bitset;
        CE_IN && IO_REQ_IN.bit_set && !IO_REQ_IN.wr &&
            (IO_REQ_IN.addr == `GPC_PORT_BASE + `GPC_DIR_OFS);
    endsequence

    req_gate_a: assert property ( // [R02]
        (IRQ_REQ_OUT & ~(pin_change_flags & group_enable_control &
            {4{GLOBAL_IRQ_EN_IN}})) == 4'h0)
        else $error("request without flag and enables");

    flag_set_a: assert property ( // [R01]
        CE_IN |=> ((pin_change_flags & $past(pc_event)) == $past(pc_event)))
        else $error("pin change did not set flag");

    ack_clear_a: assert property ( // [R03]
        (CE_IN && IRQ_ACK_IN[0] && !pc_event[0]) |=> !pin_change_flags[0])
        else $error("flag survived routine entry");

    w1c_zero_a: assert property ( // [R04]
        (CE_IN && hit_flags && IRQ_ACK_IN == 4'h0) |=>
            ((pin_change_flags & ($past(pin_change_flags) & ~$past(wr_ones[3:0]))) ==
            ($past(pin_change_flags) & ~$past(wr_ones[3:0]))))
        else $error("zero write cleared a flag");

    masked_quiet_a: assert property ( // [R06]
        (CE_IN && !pin_change_flags[1] &&
            (pin_change[15:8] & pin_change_mask[1]) == 8'h00) |=> !pin_change_flags[1])
        else $error("masked group raised flag");

    toggle_out_a: assert property ( // [R08]
        (CE_IN && plain_write && IO_REQ_IN.addr == `GPC_PORT_BASE + `GPC_PIN_OFS) |=>
            out_data_reg[0] == ($past(out_data_reg[0]) ^ $past(IO_REQ_IN.wdata)))
        else $error("sample write did not toggle out data");

    dir_follow_a: assert property ( // [R10]
        s_dir0_write ##1 port0_quiet |-> PIN_OE_OUT[7:0] == $past(IO_REQ_IN.wdata))
        else $error("direction write not seen on enables");

    bit_only_a: assert property ( // [R15]
        s_dir0_bitset |=> direction_reg[0] == ($past(direction_reg[0]) | $past(bit_onehot)))
        else $error("bit set touched other bits");

    pullup_rule_a: assert property ( // [R09]
        (PIN_PULLUP_OUT & (dir_flat | ~out_flat | {32{global_pullup_off}})) == 32'h0)
        else $error("pull-up on where it must be off");

    reset_hiz_a: assert property (@(posedge CLK_IN) disable iff (1'b0) // [R13]
        SRST_IN |-> (PIN_OE_OUT == 32'h0 && PIN_PULLUP_OUT == 32'h0))
        else $error("pins driven during reset");

    w1c_clear_a: assert property ( // [R04]
        (CE_IN && hit_flags && pc_event == 4'h0) |=>
            ((pin_change_flags & $past(flag_w1c)) == 4'h0))
        else $error("one written to a flag left it set");

    irq_raise_a: assert property ( // [R02]
        (pin_change_flags[0] && group_enable_control[0] && GLOBAL_IRQ_EN_IN) |->
            IRQ_REQ_OUT[0])
        else $error("enabled flag gave no request");

    // a low enable must hold direction, out data and flags, the read answer included
    ce_freeze_a: assert property ( // [R07]
        !CE_IN |=> (dir_flat == $past(dir_flat) && out_flat == $past(out_flat) &&
            pin_change_flags == $past(pin_change_flags) && rdata == $past(rdata)))
        else $error("state moved with enable low");

endmodule

// [tb/gpc_pin_partner.sv]
// external circuitry model on the general-purpose pins
`timescale 1ns/1ps
module gpc_pin_partner (
    // clock
    input wire logic clk_in,
    // device pad controls
    input wire logic [31:0] pin_out_in,
    input wire logic [31:0] pin_oe_in,
    input wire logic [31:0] pin_pullup_in,
    // outside drivers
    input wire logic [31:0] ext_en_in,
    input wire logic [31:0] ext_level_in,
    // resolved pin levels
    output logic [31:0] pin_level_out
);
    logic [31:0] float_q = 32'h0000_0000;
    wire logic [31:0] dev_drive = pin_oe_in & pin_out_in;
    wire logic [31:0] ext_drive = ~pin_oe_in & ext_en_in & ext_level_in;
    wire logic [31:0] idle = ~pin_oe_in & ~ext_en_in;
    // an undriven pin without pull-up wanders, so nothing may rely on it
    always_ff @(posedge clk_in) begin
        float_q <= ~float_q;
    end
    assign pin_level_out = dev_drive | ext_drive | (idle & pin_pullup_in) |
        (idle & ~pin_pullup_in & float_q);
endmodule

// [tb/gpc_gpio_port_pin_change_test.sv]
// self-checking bench for the gpio pin-change block
`timescale 1ns/1ps
`include "gpc_defines.svh"
module gpc_gpio_port_pin_change_test import gpc_pkg::*;;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rexp;
    } gpc_row_s;
    logic clk = 1'b0;
    logic srst = 1'b1;
    gpc_io_req_s io_req = '0;
    logic global_en = 1'b0;
    logic [3:0] ack = 4'h0;
    logic ce = 1'b1;
    gpc_alt_s alt = '0;
    logic [31:0] ext_en = 32'hffff_ffff;
    logic [31:0] ext_level = 32'h0000_0000;
    logic [7:0] rdata;
    logic rvalid;
    logic [3:0] irq;
    logic [31:0] pin_in, pin_out, pin_oe, pin_pu;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    gpc_row_s rows [10] = '{
        '{8'h21, 8'hff, 8'hff}, '{8'h24, 8'ha5, 8'ha5}, '{8'h2a, 8'h3c, 8'h3c},
        '{8'h22, 8'h5a, 8'h5a}, '{8'h2b, 8'h96, 8'h96}, '{8'h6b, 8'hc3, 8'hc3},
        '{8'h6c, 8'h81, 8'h81}, '{8'h6d, 8'h7e, 8'h7e}, '{8'h73, 8'h18, 8'h18},
        '{8'h50, 8'hff, 8'h00}};
    logic [7:0] mask_addr [4] = '{`GPC_MASK0_ADDR, `GPC_MASK1_ADDR, `GPC_MASK2_ADDR,
        `GPC_MASK3_ADDR};

    always #12.5 clk = ~clk;

    gpc_gpio_port_pin_change dut_u (
        .CLK_IN(clk), .SRST_IN(srst), .CE_IN(ce), .IO_REQ_IN(io_req),
        .IO_RDATA_OUT(rdata), .IO_RVALID_OUT(rvalid), .GLOBAL_IRQ_EN_IN(global_en),
        .IRQ_ACK_IN(ack), .IRQ_REQ_OUT(irq), .ALT_IN(alt), .PIN_IN(pin_in),
        .PIN_OUT(pin_out), .PIN_OE_OUT(pin_oe), .PIN_PULLUP_OUT(pin_pu));

    gpc_pin_partner partner_u (
        .clk_in(clk), .pin_out_in(pin_out), .pin_oe_in(pin_oe), .pin_pullup_in(pin_pu),
        .ext_en_in(ext_en), .ext_level_in(ext_level), .pin_level_out(pin_in));

    task automatic complete_run();
        if (fail_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // generous ceiling; the whole sequence needs well under 1500 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // one request cycle; effects are settled 1 ns after the taking edge
    task automatic io(input logic [7:0] a, input logic [7:0] d, input logic w,
        input logic r, input logic s, input logic c, input logic [2:0] b);
        @(posedge clk);
        io_req <= '{addr: a, wdata: d, wr: w, rd: r, bit_set: s, bit_clr: c, bit_sel: b};
        @(posedge clk);
        io_req <= '0;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        io(a, d, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        io(a, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0);
        check({31'h0, rvalid}, 32'h1);
        check({24'h0, rdata}, {24'h0, exp});
    endtask

    task automatic pin_flip(input int i);
        @(posedge clk);
        ext_level[i] <= ~ext_level[i];
        repeat (5) @(posedge clk);
        #1;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        #1;
        check(pin_oe | pin_pu, 32'h0);
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            rd_chk(rows[i].addr, 8'h00);
            wr(rows[i].addr, rows[i].wdata);
            rd_chk(rows[i].addr, rows[i].rexp);
            wr(rows[i].addr, 8'h00);
        end
        rd_chk(`GPC_GROUP_EN_ADDR, 8'h00);
        // port 0 pads: low nibble outputs, pull-ups on inputs 4 and 5 of the high nibble
        wr(8'h21, 8'h0f);
        wr(8'h22, 8'h35);
        check(pin_oe[7:0], 32'h0f);
        check(pin_out[3:0], 32'h5);
        check(pin_pu[7:0], 32'h30);
        wr(`GPC_CORE_CTRL_ADDR, 8'h01);
        check(pin_pu, 32'h0);
        wr(`GPC_CORE_CTRL_ADDR, 8'h00);
        check(pin_pu[7:0], 32'h30);
        wr(8'h20, 8'h03);
        rd_chk(8'h22, 8'h36);
        check(pin_out[3:0], 32'h6);
        io(8'h21, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 3'h7);
        io(8'h22, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1, 3'h1);
        rd_chk(8'h21, 8'h8f);
        rd_chk(8'h22, 8'h34);
        check(pin_pu[7:0], 32'h30);
        wr(8'h21, 8'h00);
        wr(8'h22, 8'h00);
        // undriven port 1 pin held up only by its pull-up
        wr(8'h25, 8'h02);
        @(posedge clk);
        ext_en[9] <= 1'b0;
        repeat (4) @(posedge clk);
        rd_chk(8'h23, 8'h02);
        @(posedge clk);
        ext_en[9] <= 1'b1;
        wr(8'h25, 8'h00);
        wr(`GPC_GROUP_EN_ADDR, 8'h0f);
        @(posedge clk);
        global_en <= 1'b1;
        for (int g = 0; g < 4; g++) begin
            wr(mask_addr[g], 8'h20);
            pin_flip(8 * g + 5);
            check(irq, 32'h1 << g);
            rd_chk(`GPC_FLAGS_ADDR, 8'h01 << g);
            wr(`GPC_FLAGS_ADDR, 8'h00);
            rd_chk(`GPC_FLAGS_ADDR, 8'h01 << g);
            if (g % 2 == 0) begin
                @(posedge clk);
                ack <= 4'h1 << g;
                @(posedge clk);
                ack <= 4'h0;
                #1;
            end else begin
                wr(`GPC_FLAGS_ADDR, 8'h01 << g);
            end
            rd_chk(`GPC_FLAGS_ADDR, 8'h00);
            pin_flip(8 * g + 6);
            rd_chk(`GPC_FLAGS_ADDR, 8'h00);
        end
        @(posedge clk);
        global_en <= 1'b0;
        pin_flip(5);
        check(irq, 32'h0);
        rd_chk(`GPC_FLAGS_ADDR, 8'h01);
        wr(`GPC_FLAGS_ADDR, 8'h01);
        wr(`GPC_GROUP_EN_ADDR, 8'h0e);
        pin_flip(5);
        rd_chk(`GPC_FLAGS_ADDR, 8'h00);
        // reset in mid-run releases the pads at once
        wr(8'h21, 8'hff);
        @(posedge clk);
        srst <= 1'b1;
        #1;
        check(pin_oe, 32'h0);
        @(posedge clk);
        srst <= 1'b0;
        rd_chk(8'h21, 8'h00);
        // pin 1 handed to its alternate user; its neighbours stay gpio
        wr(8'h21, 8'h0c);
        wr(8'h22, 8'h0b);
        @(posedge clk);
        alt <= '{en: 32'h2, oe: 32'h2, data: 32'h0};
        #1;
        check(pin_oe[3:0], 32'he);
        check(pin_out[3:0], 32'h9);
        check(pin_pu[3:0], 32'h1);
        // a write while the enable is low is not taken
        @(posedge clk);
        alt <= '0;
        ce <= 1'b0;
        wr(8'h22, 8'h00);
        check(pin_pu[3:0], 32'h3);
        @(posedge clk);
        ce <= 1'b1;
        rd_chk(8'h22, 8'h0b);
        complete_run();
    end
endmodule
